// [ulpi_dual_role_control_reg_intr_rise_enable_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module ulpi_dual_role_control_reg_intr_rise_enable_tb;
   logic       clk, rst, fault_in, low_power_entry, ulpi_clk, ulpi_stp;
   logic       ulpi_data_oe, ulpi_dir, ulpi_nxt, power_switch_out_n, power_switch_oe;
   logic       external_indicator_select, supply_drive_request, supply_charge;
   logic       supply_discharge, minus_line_pull_low, plus_line_pull_low, event_irq;
   logic [1:0] line_state;
   logic [3:0] src;
   logic [7:0] ulpi_data_in, ulpi_data_out, ctl_seen, got;
   int         n_fail, comparisons, seed, a, d, m_ctrl, m_rise;

   ulpirg_top i_dut
   (
      .clk, .rst, .ulpi_clk, .ulpi_stp, .ulpi_data_in, .ulpi_data_out, .ulpi_data_oe,
      .ulpi_dir, .ulpi_nxt, .session_over_flag(src[3]), .session_ok_flag(src[2]),
      .supply_ok_comparator(src[1]), .host_detach_flag(src[0]), .fault_in, .line_state,
      .low_power_entry, .power_switch_out_n, .power_switch_oe, .external_indicator_select,
      .supply_drive_request, .supply_charge, .supply_discharge, .minus_line_pull_low,
      .plus_line_pull_low, .event_irq
   );

   ulpirg_link i_link
   (
      .ulpi_clk, .ulpi_stp, .ulpi_data_in, .ulpi_dir, .ulpi_nxt, .ulpi_data_oe, .ulpi_data_out
   );

   // Control outputs in register bit order, reserved bit read as zero
   assign ctl_seen = {external_indicator_select, power_switch_oe, supply_drive_request,
                      supply_charge, supply_discharge, minus_line_pull_low,
                      plus_line_pull_low, 1'b0};

   // System clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input int exp);
      comparisons++;
      if (seen !== exp[7:0])
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp[7:0], seen);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic reset_dut();
      @(negedge clk);
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      m_ctrl = 'h06;
      m_rise = 'h1F;
      repeat (8) @(negedge clk);
   endtask

   // Access plus model update; unmapped writes change nothing
   task automatic wr(input int wa, input int v);
      i_link.wr(wa[5:0], v[7:0]);
      case (wa)
         'h0A: m_ctrl = v;
         'h0B: m_ctrl = m_ctrl | v;
         'h0C: m_ctrl = m_ctrl & ~v;
         'h0D: m_rise = v;
         'h0E: m_rise = m_rise | v;
         'h0F: m_rise = m_rise & ~v;
         default: ;
      endcase
   endtask

   task automatic rd_chk(input int ra, input int exp);
      i_link.rd(ra[5:0], got);
      check("register read", got, exp);
   endtask

   task automatic chk_ctrl();
      repeat (4) @(negedge clk);
      check("control outputs", ctl_seen, m_ctrl & 'hFE);
   endtask

   // One source rise, index 4 meaning the external indicator pin
   task automatic rise_case(input int j, input int en);
      int b, hit, lvl;
      b = (j == 4) ? 1 : j;
      wr('h0D, en);
      i_link.rxq.delete();
      @(negedge clk);
      line_state = $random(seed);
      if (j == 4) fault_in = 1'b1;
      else src[j] = 1'b1;
      repeat (100) @(negedge clk);
      hit = (en >> b) & 1;
      lvl = (m_ctrl[7] ? fault_in : src[1]) ? 3 : src[2] ? 2 : !src[3] ? 1 : 0;
      check("event irq", {7'h00, event_irq}, hit);
      check("report count", 8'(i_link.rxq.size()), hit);
      if (hit) check("report byte", i_link.rxq[0], {lvl[1:0], line_state});
      rd_chk('h13, 1 << b);
      rd_chk('h14, hit << b);
      repeat (4) @(negedge clk);
      check("irq after latch read", {7'h00, event_irq}, 0);
      fault_in = 1'b0;
      src = 4'h0;
      repeat (100) @(negedge clk);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      seed = 896;
      n_fail = 0;
      comparisons = 0;
      rst = 1'b1;
      fault_in = 1'b0;
      low_power_entry = 1'b0;
      line_state = 2'h0;
      src = 4'h0;
      reset_dut();
      for (a = 'h0A; a < 'h10; a++) rd_chk(a, a < 'h0D ? m_ctrl : m_rise);
      chk_ctrl();
      // Every access kind with random data
      repeat (3)
         for (a = 'h0A; a < 'h10; a++)
         begin
            d = $random(seed) & 'hFF;
            if (a < 'h0D) d = d & 'hFE;
            wr(a, d);
            chk_ctrl();
            rd_chk(a, a < 'h0D ? m_ctrl : m_rise);
         end
      // Unmapped place: write ignored, read gives zero
      wr('h30, 'hFF);
      rd_chk('h0A, m_ctrl);
      rd_chk('h30, 0);
      // Each source enabled alone, then masked alone
      wr('h0A, 'h06);
      for (a = 0; a < 4; a++)
      begin
         rise_case(a, 1 << a);
         rise_case(a, ~(1 << a) & 'hF);
      end
      // External pin as supply-ok source
      wr('h0B, 'h80);
      chk_ctrl();
      rise_case(4, 'h02);
      wr('h0C, 'h80);
      // Low-power entry clears the latch
      wr('h0D, 'h1F);
      @(negedge clk);
      src[0] = 1'b1;
      repeat (100) @(negedge clk);
      check("irq before low power", {7'h00, event_irq}, 1);
      low_power_entry = 1'b1;
      repeat (20) @(negedge clk);
      check("irq in low power", {7'h00, event_irq}, 0);
      low_power_entry = 1'b0;
      rd_chk('h14, 0);
      src = 4'h0;
      repeat (100) @(negedge clk);
      // Second reset in mid-run
      wr('h0A, 'hF8);
      reset_dut();
      rd_chk('h0C, 'h06);
      rd_chk('h0F, 'h1F);
      chk_ctrl();
      conclude();
   end

   // Watchdog, about five times the expected run
   initial
   begin
      #300000;
      n_fail++;
      conclude();
   end
endmodule // ulpi_dual_role_control_reg_intr_rise_enable_tb

`default_nettype wire

// [ulpirg_consts.vh]
`ifndef ULPIRG_CONSTS_VH
`define ULPIRG_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses (6-bit immediate address space)
// ----------------------------------------------------------------
`define ULPIRG_ADDR_CTRL_WR      6'h0A
`define ULPIRG_ADDR_CTRL_SET     6'h0B
`define ULPIRG_ADDR_CTRL_CLR     6'h0C
`define ULPIRG_ADDR_RISE_WR      6'h0D
`define ULPIRG_ADDR_RISE_SET     6'h0E
`define ULPIRG_ADDR_RISE_CLR     6'h0F
`define ULPIRG_ADDR_STATUS       6'h13
`define ULPIRG_ADDR_LATCH        6'h14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ULPIRG_CTRL_RESET        8'h06
`define ULPIRG_RISE_RESET        8'h1F

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define ULPIRG_CTRL_EXT_IND      7
`define ULPIRG_CTRL_EXT_DRIVE    6
`define ULPIRG_CTRL_DRIVE_REQ    5
`define ULPIRG_CTRL_CHARGE       4
`define ULPIRG_CTRL_DISCHARGE    3
`define ULPIRG_CTRL_MINUS_PD     2
`define ULPIRG_CTRL_PLUS_PD      1

// ----------------------------------------------------------------
// Event source bit positions (status, enable and latch alike)
// ----------------------------------------------------------------
`define ULPIRG_EVT_SESSION_OVER  3
`define ULPIRG_EVT_SESSION_OK    2
`define ULPIRG_EVT_SUPPLY_OK     1
`define ULPIRG_EVT_HOST_DETACH   0

// ----------------------------------------------------------------
// Link command byte fields
// ----------------------------------------------------------------
`define ULPIRG_CMD_WRITE         2'b10
`define ULPIRG_CMD_READ          2'b11

// ----------------------------------------------------------------
// Link-side protocol states
// ----------------------------------------------------------------
`define ULPIRG_ST_IDLE           3'h0
`define ULPIRG_ST_WR_DATA        3'h1
`define ULPIRG_ST_WR_STOP        3'h2
`define ULPIRG_ST_RD_ACK         3'h3
`define ULPIRG_ST_RD_TURN        3'h4
`define ULPIRG_ST_RD_DATA        3'h5
`define ULPIRG_ST_RX_TURN        3'h6
`define ULPIRG_ST_RX_DATA        3'h7

// ----------------------------------------------------------------
// Synchroniser width: clock, stop, data, four sources, fault,
// line state, low-power entry
// ----------------------------------------------------------------
`define ULPIRG_SYNC_W            18

`endif

// [ulpirg_link.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Link controller model: register accesses and report capture
// ----------------------------------------------------------------
module ulpirg_link
(
   // Link-driven pins
   output logic       ulpi_clk,
   output logic       ulpi_stp,
   output logic [7:0] ulpi_data_in,
   // Device-driven pins
   input  wire logic       ulpi_dir,
   input  wire logic       ulpi_nxt,
   input  wire logic       ulpi_data_oe,
   input  wire logic [7:0] ulpi_data_out
);
   logic       in_read;
   logic [7:0] rxq[$];

   // Free-running link clock, phase unrelated to the system clock
   initial
   begin
      ulpi_clk = 1'b0;
      ulpi_stp = 1'b0;
      ulpi_data_in = 8'h00;
      in_read = 1'b0;
      #3;
      forever #62.5 ulpi_clk = ~ulpi_clk;
   end

   // Report bytes are whatever the device drives outside a read
   always @(negedge ulpi_clk)
      if (ulpi_data_oe && !in_read)
         rxq.push_back(ulpi_data_out);

   // Command held until acknowledged, then data, then stop
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge ulpi_clk);
      ulpi_data_in = {2'b10, a};
      for (int i = 0; i < 8 && !ulpi_nxt; i++) @(negedge ulpi_clk);
      ulpi_data_in = d;
      @(negedge ulpi_clk);
      ulpi_stp = 1'b1;
      @(negedge ulpi_clk);
      ulpi_stp = 1'b0;
      ulpi_data_in = 8'h00;
   endtask

   // Bus inverted while released, so no stale command is seen
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      d = 'x;
      @(negedge ulpi_clk);
      ulpi_data_in = {2'b11, a};
      for (int i = 0; i < 8 && !ulpi_nxt; i++) @(negedge ulpi_clk);
      in_read = 1'b1;
      ulpi_data_in = ~ulpi_data_in;
      for (int i = 0; i < 8 && !ulpi_data_oe; i++) @(negedge ulpi_clk);
      if (ulpi_data_oe)
         d = ulpi_data_out;
      for (int i = 0; i < 8 && ulpi_dir; i++) @(negedge ulpi_clk);
      in_read = 1'b0;
      ulpi_data_in = 8'h00;
   endtask
endmodule // ulpirg_link

`default_nettype wire

// [ulpirg_sync.v]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Two-stage synchroniser, one chain per bit
// ----------------------------------------------------------------
module ulpirg_sync
#(
   parameter WIDTH = 1
)
(
   // Clock and reset
   input  wire             clk,
   input  wire             rst,
   // Asynchronous inputs
   input  wire [WIDTH-1:0] async_in,
   // Synchronised outputs
   output wire [WIDTH-1:0] sync_out
);

   genvar i;

   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_chain
         reg stage1;
         reg stage2;

         // First stage feeds only the second
         always @(posedge clk)
         begin
            if (rst)
            begin
               stage1 <= 1'b0;
               stage2 <= 1'b0;
            end
            else
            begin
               stage1 <= async_in[i];
               stage2 <= stage1;
            end
         end

         assign sync_out[i] = stage2;
      end
   endgenerate

endmodule // ulpirg_sync

`default_nettype wire

// [ulpirg_top.v]
// Functional notes
// R1: Control register reads at 0Ah-0Ch; plain write 0Ah, set 0Bh, clear 0Ch.
// R2: Rise enable register reads at 0Dh-0Fh; plain write 0Dh, set 0Eh, clear 0Fh.
// R3: Set ORs in written ones, clear drops them, zeros leave bits alone.
// R4: Control bit 7 picks the supply-ok source: zero comparator, one fault pin.
// R5: Control bit 6 at one pulls the power switch pin low, else leaves it undriven.
// R6: Control bit 5 requests 5 V supply drive, optional when bit 6 is one.
// R7: Control bit 4 charges the supply; the link first checks discharge and 2 ms SE0.
// R8: Control bit 3 discharges the supply until the link sees a session over rise.
// R9: Control bit 2 connects the minus-line 15 kOhm pull-down; resets to one.
// R10: Control bit 1 connects the plus-line 15 kOhm pull-down; resets to one.
// R11: The link never writes one to reserved control bit 0.
// R12: An enabled source rise raises the interrupt and queues a receive command.
// R13: Enable bits 3..0: session over, session ok, supply ok, host detach; 7-4 reserved.
// R14: After reset the enable register holds 1Fh, every rise enabled.
// R15: Status shows the live comparator and detector outputs.
// R16: An enabled rise sets its latch bit; a latch read or low-power entry clears it.
`timescale 1ns/10ps
`default_nettype none
`include "ulpirg_consts.vh"

module ulpirg_top
(
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Link interface, sampled on detected link clock rises
   input  wire       ulpi_clk,
   input  wire       ulpi_stp,
   input  wire [7:0] ulpi_data_in,
   output reg  [7:0] ulpi_data_out,
   output reg        ulpi_data_oe,
   output reg        ulpi_dir,
   output reg        ulpi_nxt,
   // Analog event sources and pins
   input  wire       session_over_flag,
   input  wire       session_ok_flag,
   input  wire       supply_ok_comparator,
   input  wire       host_detach_flag,
   input  wire       fault_in,
   input  wire [1:0] line_state,
   input  wire       low_power_entry,
   // Supply and pull-down controls
   output wire       power_switch_out_n,
   output reg        power_switch_oe,
   output reg        external_indicator_select,
   output reg        supply_drive_request,
   output reg        supply_charge,
   output reg        supply_discharge,
   output reg        minus_line_pull_low,
   output reg        plus_line_pull_low,
   // Event indication
   output reg        event_irq
);
   // ----------------------------------------------------------------
   // Register update helpers
   // ----------------------------------------------------------------
   // Plain, set or clear write picked by the address within a triplet
   function [7:0] apply_write;
      input [7:0] old_val;
      input [7:0] wval;
      input [1:0] kind;
      begin
         case (kind)
            2'h0:    apply_write = wval;
            2'h1:    apply_write = old_val | wval;
            2'h2:    apply_write = old_val & ~wval;
            default: apply_write = old_val;
         endcase
      end
   endfunction
   // Position of an address within the triplet starting at base
   function [1:0] triplet_kind;
      input [5:0] addr;
      input [5:0] base;
      begin
         triplet_kind = addr[1:0] - base[1:0];
      end
   endfunction
   // True when addr falls in the three-address window at base
   function in_triplet;
      input [5:0] addr;
      input [5:0] base;
      begin
         in_triplet = (addr >= base) && (addr <= base + 6'h02);
      end
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   wire [`ULPIRG_SYNC_W-1:0] sync_bus;
   ulpirg_sync #(.WIDTH (`ULPIRG_SYNC_W)) u_sync
   (
      .clk      (clk),
      .rst      (rst),
      .async_in ({ulpi_clk, ulpi_stp, ulpi_data_in,
                  session_over_flag, session_ok_flag,
                  supply_ok_comparator, host_detach_flag,
                  fault_in, line_state, low_power_entry}),
      .sync_out (sync_bus)
   );
   // Fields of the synchronised bus, in packing order
   wire       link_clk_s   = sync_bus[17];
   wire       stp_s        = sync_bus[16];
   wire [7:0] data_s       = sync_bus[15:8];
   wire [3:0] sources_s    = sync_bus[7:4];
   wire       fault_s      = sync_bus[3];
   wire [1:0] line_state_s = sync_bus[2:1];
   wire       low_power_s  = sync_bus[0];

   // ----------------------------------------------------------------
   // Link clock edge detection
   // ----------------------------------------------------------------
   reg  link_clk_prev;
   // Works on the synchronised copy, never on the first stage
   always @(posedge clk)
   begin
      if (rst)
         link_clk_prev <= 1'b0;
      else
         link_clk_prev <= link_clk_s;
   end
   wire link_tick = link_clk_s & ~link_clk_prev;

   // ----------------------------------------------------------------
   // Registers and event state
   // ----------------------------------------------------------------
   reg  [7:0] dual_role_control_reg;
   reg  [7:0] rise_event_enable_reg;
   reg  [3:0] event_source_status_reg;
   reg  [3:0] event_latch_reg;
   reg        rxcmd_pending;
   reg  [2:0] state;
   reg  [5:0] cmd_addr;
   reg  [7:0] wr_data;
   wire       rxcmd_sent;
   // Supply-ok follows the fault pin or the comparator
   wire [3:0] live_sources = {sources_s[3:2],
      dual_role_control_reg[`ULPIRG_CTRL_EXT_IND] ? fault_s : sources_s[1],
      sources_s[0]}; // see R4
   // Enabled rises against the previously seen levels
   wire [3:0] rise_hits = live_sources & ~event_source_status_reg
                          & rise_event_enable_reg[3:0]; // see R12 see R13
   // Status follows the sources every cycle
   always @(posedge clk)
   begin
      if (rst)
         event_source_status_reg <= 4'h0;
      else
         event_source_status_reg <= live_sources; // see R15
   end
   wire latch_read_done = link_tick && (state == `ULPIRG_ST_RD_DATA)
                          && (cmd_addr == `ULPIRG_ADDR_LATCH);
   // Latch: a rise in the clearing cycle survives the clear
   always @(posedge clk)
   begin
      if (rst)
         event_latch_reg <= 4'h0;
      else if (latch_read_done || low_power_s)
         event_latch_reg <= rise_hits; // see R16
      else
         event_latch_reg <= event_latch_reg | rise_hits; // see R16
   end
   // Interrupt level follows any latched event
   always @(posedge clk)
   begin
      if (rst)
         event_irq <= 1'b0;
      else
         event_irq <= |(event_latch_reg | rise_hits); // see R12
   end
   // Queued receive command; a new rise wins over the send
   always @(posedge clk)
   begin
      if (rst)
         rxcmd_pending <= 1'b0;
      else if (|rise_hits)
         rxcmd_pending <= 1'b1; // see R12
      else if (rxcmd_sent)
         rxcmd_pending <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   wire wr_commit = link_tick && (state == `ULPIRG_ST_WR_STOP) && stp_s;
   // Both triplets share the write helper
   always @(posedge clk)
   begin
      if (rst)
      begin
         dual_role_control_reg <= `ULPIRG_CTRL_RESET; // see R9 see R10
         rise_event_enable_reg <= `ULPIRG_RISE_RESET; // see R14
      end
      else if (wr_commit)
      begin
         if (in_triplet(cmd_addr, `ULPIRG_ADDR_CTRL_WR))
            dual_role_control_reg <= apply_write(dual_role_control_reg, wr_data,
               triplet_kind(cmd_addr, `ULPIRG_ADDR_CTRL_WR)); // see R1 see R3
         if (in_triplet(cmd_addr, `ULPIRG_ADDR_RISE_WR))
            rise_event_enable_reg <= apply_write(rise_event_enable_reg, wr_data,
               triplet_kind(cmd_addr, `ULPIRG_ADDR_RISE_WR)); // see R2 see R3
      end
   end

   // ----------------------------------------------------------------
   // Control outputs
   // ----------------------------------------------------------------
   wire [7:0] ctrl_reset_word = `ULPIRG_CTRL_RESET;
   // Bit 0 is stored only; nothing here acts on it
   always @(posedge clk)
   begin
      if (rst)
         {external_indicator_select, power_switch_oe, supply_drive_request, supply_charge,
          supply_discharge, minus_line_pull_low, plus_line_pull_low} <= ctrl_reset_word[7:1];
      else
      begin
         power_switch_oe           <= dual_role_control_reg[`ULPIRG_CTRL_EXT_DRIVE]; // see R5
         external_indicator_select <= dual_role_control_reg[`ULPIRG_CTRL_EXT_IND]; // see R4
         supply_drive_request      <= dual_role_control_reg[`ULPIRG_CTRL_DRIVE_REQ]; // see R6
         supply_charge             <= dual_role_control_reg[`ULPIRG_CTRL_CHARGE]; // see R7
         supply_discharge          <= dual_role_control_reg[`ULPIRG_CTRL_DISCHARGE]; // see R8
         minus_line_pull_low       <= dual_role_control_reg[`ULPIRG_CTRL_MINUS_PD]; // see R9
         plus_line_pull_low        <= dual_role_control_reg[`ULPIRG_CTRL_PLUS_PD]; // see R10
      end
   end
   // Open drain: only ever pulls low
   assign power_switch_out_n = 1'b0; // see R5

   // ----------------------------------------------------------------
   // Read data and receive command byte
   // ----------------------------------------------------------------
   reg [7:0] rd_value;
   // Unmapped addresses read as zero
   always @*
   begin
      rd_value = 8'h00;
      if (in_triplet(cmd_addr, `ULPIRG_ADDR_CTRL_WR))
         rd_value = dual_role_control_reg; // see R1
      else if (in_triplet(cmd_addr, `ULPIRG_ADDR_RISE_WR))
         rd_value = rise_event_enable_reg; // see R2
      else if (cmd_addr == `ULPIRG_ADDR_STATUS)
         rd_value = {4'h0, event_source_status_reg}; // see R15
      else if (cmd_addr == `ULPIRG_ADDR_LATCH)
         rd_value = {4'h0, event_latch_reg}; // see R16
   end
   // Supply level code from the comparator ladder
   wire [1:0] supply_level =
      event_source_status_reg[`ULPIRG_EVT_SUPPLY_OK]     ? 2'h3 :
      event_source_status_reg[`ULPIRG_EVT_SESSION_OK]    ? 2'h2 :
      !event_source_status_reg[`ULPIRG_EVT_SESSION_OVER] ? 2'h1 : 2'h0;
   assign rxcmd_sent = link_tick && (state == `ULPIRG_ST_RX_DATA);

   // ----------------------------------------------------------------
   // Link protocol state machine, one step per link clock rise
   // ----------------------------------------------------------------
   // A link command in idle always wins over a queued report
   always @(posedge clk)
   begin
      if (rst)
      begin
         state         <= `ULPIRG_ST_IDLE;
         cmd_addr      <= 6'h00;
         wr_data       <= 8'h00;
         ulpi_data_out <= 8'h00;
         ulpi_data_oe  <= 1'b0;
         ulpi_dir      <= 1'b0;
         ulpi_nxt      <= 1'b0;
      end
      else if (link_tick)
      begin
         case (state)
            `ULPIRG_ST_IDLE:
            begin
               if ((data_s[7:6] == `ULPIRG_CMD_WRITE) || (data_s[7:6] == `ULPIRG_CMD_READ))
               begin
                  cmd_addr <= data_s[5:0];
                  ulpi_nxt <= 1'b1;
                  state    <= (data_s[7:6] == `ULPIRG_CMD_READ) ? `ULPIRG_ST_RD_ACK
                                                               : `ULPIRG_ST_WR_DATA;
               end
               else if (rxcmd_pending && !stp_s)
               begin
                  ulpi_dir <= 1'b1; // see R12
                  state    <= `ULPIRG_ST_RX_TURN;
               end
            end
            `ULPIRG_ST_WR_DATA:
            begin
               wr_data <= data_s;
               state   <= `ULPIRG_ST_WR_STOP;
            end
            `ULPIRG_ST_WR_STOP:
            begin
               ulpi_nxt <= 1'b0;
               state    <= `ULPIRG_ST_IDLE;
            end
            `ULPIRG_ST_RD_ACK:
            begin
               ulpi_nxt <= 1'b0;
               ulpi_dir <= 1'b1;
               state    <= `ULPIRG_ST_RD_TURN;
            end
            `ULPIRG_ST_RD_TURN:
            begin
               ulpi_data_out <= rd_value;
               ulpi_data_oe  <= 1'b1;
               state         <= `ULPIRG_ST_RD_DATA;
            end
            `ULPIRG_ST_RX_TURN:
            begin
               ulpi_data_out <= {4'h0, supply_level, line_state_s}; // see R12
               ulpi_data_oe  <= 1'b1;
               state         <= `ULPIRG_ST_RX_DATA;
            end
            `ULPIRG_ST_RD_DATA, `ULPIRG_ST_RX_DATA:
            begin
               ulpi_data_oe <= 1'b0;
               ulpi_dir     <= 1'b0;
               state        <= `ULPIRG_ST_IDLE;
            end
            default:
            begin
               ulpi_data_oe <= 1'b0;
               ulpi_dir     <= 1'b0;
               ulpi_nxt     <= 1'b0;
               state        <= `ULPIRG_ST_IDLE;
            end
         endcase
      end
   end

endmodule // ulpirg_top

`default_nettype wire

// [ulpirg_top_assertions.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Port checker for the dual-role control and rise enable block
// ----------------------------------------------------------------
module ulpirg_top_assertions
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link handshake
   input wire logic ulpi_dir,
   input wire logic ulpi_nxt,
   input wire logic ulpi_data_oe,
   // Event sources
   input wire logic session_over_flag,
   input wire logic session_ok_flag,
   input wire logic supply_ok_comparator,
   input wire logic host_detach_flag,
   input wire logic fault_in,
   input wire logic low_power_entry,
   // Controls and indication
   input wire logic power_switch_out_n,
   input wire logic power_switch_oe,
   input wire logic external_indicator_select,
   input wire logic supply_drive_request,
   input wire logic supply_charge,
   input wire logic supply_discharge,
   input wire logic minus_line_pull_low,
   input wire logic plus_line_pull_low,
   input wire logic event_irq
);
   logic [6:0] ctrl_vec;
   logic [5:0] rise_hist;
   logic [3:0] nxt_hist;

   // Control outputs in register bit order 7 down to 1
   assign ctrl_vec = {external_indicator_select, power_switch_oe, supply_drive_request,
                      supply_charge, supply_discharge, minus_line_pull_low, plus_line_pull_low};

   // Recent causes; reset counts, since a source high at release is reported
   always @(posedge clk)
   begin
      rise_hist <= {rise_hist[4:0], rst | $rose(session_over_flag) | $rose(session_ok_flag)
                    | $rose(supply_ok_comparator) | $rose(host_detach_flag) | $rose(fault_in)
                    | $changed(external_indicator_select)};
      nxt_hist  <= {nxt_hist[2:0], rst | $fell(ulpi_nxt)};
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_PSW_OPEN_DRAIN: assert property (power_switch_oe |-> !power_switch_out_n)
      else $error("power switch pin not pulled low while enabled");
   AST_PULL_RESET: assert property ($fell(rst) |-> minus_line_pull_low && plus_line_pull_low)
      else $error("line pull-downs not connected after reset");
   AST_CTRL_RESET: assert property ($fell(rst) |-> ctrl_vec[6:2] == 5'h00)
      else $error("supply controls not idle after reset");
   AST_IRQ_RESET: assert property ($fell(rst) |-> !event_irq)
      else $error("event indication set after reset");
   AST_IRQ_CAUSE: assert property ($rose(event_irq) |-> rise_hist != 6'h00)
      else $error("event indication rose with no source rise");
   AST_LP_CLEAR: assert property ((low_power_entry && rise_hist == 6'h00) [*6] |-> !event_irq)
      else $error("latch not cleared in low-power mode");
   AST_DIR_BEFORE_DATA: assert property ($rose(ulpi_data_oe) |-> ulpi_dir && $past(ulpi_dir))
      else $error("device drove data without turnaround");
   AST_CTRL_AFTER_ACCESS: assert property (!$stable(ctrl_vec) |-> nxt_hist != 4'h0)
      else $error("control output changed with no register access");
endmodule // ulpirg_top_assertions

bind ulpirg_top ulpirg_top_assertions i_chk
(
   .clk, .rst, .ulpi_dir, .ulpi_nxt, .ulpi_data_oe, .session_over_flag, .session_ok_flag,
   .supply_ok_comparator, .host_detach_flag, .fault_in, .low_power_entry, .power_switch_out_n,
   .power_switch_oe, .external_indicator_select, .supply_drive_request, .supply_charge,
   .supply_discharge, .minus_line_pull_low, .plus_line_pull_low, .event_irq
);

`default_nettype wire
